// >>> rtl/pci_target_image_decode.sv
// pci target address-phase decoder with window control registers
`timescale 1ns/1ps
`default_nettype none
`include "pci_target_image_decode_params.svh"

// Function
// - claim master accesses bound for forwarding
// - decode only memory and configuration commands
// - positively claim addresses inside programmed range
// - window placed by base, sized by code
// - range decode applies to memory only
// - accept memory read, write, multiple, line
// - configuration read/write only as type 0
// - never claim io, ack, special, dual, reserved
// - write and invalidate treated as write
// - decode enable gates window, reset off
// - translation enable per window, reset off
// - base register gated by base enable
// - size is 64K times two to code
// - space select picks memory or io forwarding
// - port select picks processor or other pci
// - exact read forwards latched byte enables on reads to the other pci
// - read and write transfer types driven
// - global coherency control, asserted by default
// - cache inhibit control, asserted by default
// - prefetch retention flag, reset off
// - byte order field, big-endian at reset
module pci_target_image_decode
   import pci_target_image_decode_pkg::*;
#(
   parameter int         NUM_IMAGES     = 4,
   parameter logic [4:0] READ_TT_RESET  = 5'h00,
   parameter logic [4:0] WRITE_TT_RESET = 5'h01,
   localparam int        IDX_W          = (NUM_IMAGES > 1) ? $clog2(NUM_IMAGES) : 1
) (
   input  wire logic                clk_i,
   input  wire logic                nrst_i,
   input  wire logic                pci_frame_n_i,
   input  wire logic                pci_irdy_n_i,
   input  wire logic                pci_idsel_i,
   input  wire logic [31:0]         pci_addr_data_lines_i,
   input  wire logic [3:0]          pci_cmd_byte_enables_i,
   input  wire logic                reg_wr_i,
   input  wire logic                reg_rd_i,
   input  wire logic [IDX_W-1:0]    reg_image_i,
   input  wire logic                reg_sel_i,
   input  wire logic [31:0]         reg_wdata_i,
   output logic [31:0]              reg_rdata_o,
   output logic                     reg_rvalid_o,
   input  wire logic                eeprom_load_i,
   input  wire logic [IDX_W-1:0]    eeprom_image_i,
   input  wire logic [3:0]          eeprom_size_code_i,
   input  wire logic                eeprom_base_reg_en_i,
   output logic                     claim_o,
   output logic                     config_claim_o,
   output logic [IDX_W-1:0]         claim_image_o,
   output logic [31:0]              fwd_addr_o,
   output logic [3:0]               fwd_cmd_o,
   output logic                     fwd_write_o,
   output logic [3:0]               fwd_byte_enables_n_o,
   output logic                     target_port_select_o,
   output logic                     fwd_io_space_o,
   output logic                     fwd_exact_read_o,
   output logic                     translation_enable_o,
   output logic [3:0]               window_size_code_o,
   output logic [4:0]               proc_transfer_type_lines_o,
   output logic                     proc_global_signal_n_o,
   output logic                     proc_cache_inhibit_signal_n_o,
   output logic                     prefetch_retain_o,
   output logic [1:0]               byte_order_o
);

   localparam int BASE_W = 32 - `WINDOW_GRAIN_BITS;

   // whole state of the decoder
   typedef struct packed {
      bus_state_t                          bus;
      ctl_t       [NUM_IMAGES-1:0]         ctl;
      logic       [NUM_IMAGES-1:0][BASE_W-1:0] base;
      logic                                pend_mem;
      logic                                pend_cfg;
      logic       [IDX_W-1:0]              pend_image;
      logic       [31:0]                   pend_addr;
      logic       [3:0]                    pend_cmd;
      logic       [31:0]                   rdata;
      logic                                rvalid;
      logic                                claim;
      logic                                cfg_claim;
      logic       [IDX_W-1:0]              image;
      logic       [31:0]                   addr;
      logic       [3:0]                    cmd;
      logic                                write;
      logic       [3:0]                    be_n;
      logic       [4:0]                    tt;
      ctl_t                                attr;
   } state_t;

   state_t                  st;
   state_t                  next_st;
   logic [NUM_IMAGES-1:0]   hit;
   logic                    addr_phase;
   logic                    mem_cmd;
   logic                    cfg_type0;
   logic                    any_hit;
   logic [IDX_W-1:0]        hit_image;

   // refuse window counts outside the range 1 to 8
   if (NUM_IMAGES < 1 || NUM_IMAGES > 8)
   begin : g_bad_count
      $error("NUM_IMAGES must lie between 1 and 8");
   end

   // reset value of one window control register
   function automatic ctl_t ctl_reset();
      ctl_t c;
      c                          = '0;
      c.window_decode_enable     = `RST_DECODE_EN;
      c.translation_enable       = `RST_XLATE_EN;
      c.base_reg_enable          = `RST_BASE_REG_EN;
      c.window_size_code         = `RST_SIZE_CODE;
      c.io_space_select          = `RST_IO_SPACE;
      c.target_port_select       = `RST_PORT_SEL;
      c.exact_read_enable        = `RST_EXACT_READ;
      c.proc_read_transfer_type  = READ_TT_RESET;
      c.proc_write_transfer_type = WRITE_TT_RESET;
      c.coherency_global_ctl     = `RST_GLOBAL_CTL;
      c.cache_inhibit_ctl        = `RST_CI_CTL;
      c.prefetch_retain_enable   = `RST_PREFETCH;
      c.byte_order               = `RST_BYTE_ORDER;
      return c;
   endfunction

   // reset value of the whole state
   function automatic state_t state_reset();
      state_t s;
      s     = '0;
      s.bus = BUS_IDLE;
      for (int i = 0; i < NUM_IMAGES; i++)
      begin
         s.ctl[i]  = ctl_reset();
         s.base[i] = `RST_BASE;
      end
      s.attr = ctl_reset();
      return s;
   endfunction

   // range compare, one per window
   for (genvar g = 0; g < NUM_IMAGES; g++)
   begin : g_match
      window_match #(
         .BASE_W      (BASE_W)
      ) u_match (
         .enable_i    (st.ctl[g].window_decode_enable),
         .mem_cmd_i   (mem_cmd),
         .base_i      (st.base[g]),
         .size_code_i (st.ctl[g].window_size_code),
         .addr_i      (pci_addr_data_lines_i),
         .hit_o       (hit[g])
      );
   end

   // command classes seen in the address phase
   assign addr_phase = (st.bus == BUS_IDLE) && !pci_frame_n_i;
   assign mem_cmd    = is_mem_cmd(pci_cmd_byte_enables_i);
   assign cfg_type0  = is_cfg_cmd(pci_cmd_byte_enables_i) && pci_idsel_i
                    && (pci_addr_data_lines_i[1:0] == `TYPE0_ADDR_TAG);

   // lowest numbered hitting window wins on overlap
   always_comb
   begin
      any_hit   = 1'b0;
      hit_image = '0;
      for (int i = NUM_IMAGES - 1; i >= 0; i--)
      begin
         if (hit[i])
         begin
            any_hit   = 1'b1;
            hit_image = IDX_W'(i);
         end
      end
   end

   // next state: bus tracking, claims, register access
   always_comb
   begin
      next_st           = st;
      next_st.claim     = 1'b0;
      next_st.cfg_claim = 1'b0;
      next_st.rvalid    = 1'b0;

      // address phase tracking
      unique case (st.bus)
         BUS_IDLE:
         begin
            if (addr_phase)
            begin
               next_st.bus        = BUS_LANES;
               next_st.pend_mem   = any_hit;
               next_st.pend_cfg   = cfg_type0;
               next_st.pend_image = hit_image;
               next_st.pend_addr  = pci_addr_data_lines_i;
               next_st.pend_cmd   = pci_cmd_byte_enables_i;
            end
         end
         BUS_LANES:
         begin
            // first data phase: byte enables now on the command lines
            next_st.bus       = BUS_BUSY;
            next_st.claim     = st.pend_mem;
            next_st.cfg_claim = st.pend_cfg;
            if (st.pend_mem)
            begin
               next_st.image = st.pend_image;
               next_st.addr  = st.pend_addr;
               next_st.attr  = st.ctl[st.pend_image];
               next_st.write = is_write_cmd(st.pend_cmd);
               // write and invalidate goes out as plain write
               next_st.cmd   = (st.pend_cmd == CMD_MEM_WR_INV) ? CMD_MEM_WR : st.pend_cmd;
               next_st.tt    = is_write_cmd(st.pend_cmd)
                             ? st.ctl[st.pend_image].proc_write_transfer_type
                             : st.ctl[st.pend_image].proc_read_transfer_type;
               // exact lanes only for reads sent to the other pci bus
               next_st.be_n  = (st.ctl[st.pend_image].exact_read_enable
                             && st.ctl[st.pend_image].target_port_select
                             && !is_write_cmd(st.pend_cmd))
                             ? pci_cmd_byte_enables_i : `ALL_LANES_N;
            end
            else if (st.pend_cfg)
            begin
               next_st.addr  = st.pend_addr;
               next_st.cmd   = st.pend_cmd;
               next_st.write = is_write_cmd(st.pend_cmd);
               next_st.be_n  = pci_cmd_byte_enables_i;
            end
            if (pci_frame_n_i && pci_irdy_n_i)
            begin
               next_st.bus = BUS_IDLE;
            end
         end
         BUS_BUSY:
         begin
            if (pci_frame_n_i && pci_irdy_n_i)
            begin
               next_st.bus = BUS_IDLE;
            end
         end
         default:
         begin
            next_st.bus = BUS_IDLE;
         end
      endcase

      // register read, base hidden while its enable is clear
      if (reg_rd_i)
      begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = '0;
         if (32'(reg_image_i) < NUM_IMAGES)
         begin
            if (reg_sel_i == `REG_SEL_CONTROL)
            begin
               next_st.rdata = st.ctl[reg_image_i];
            end
            else if (st.ctl[reg_image_i].base_reg_enable)
            begin
               next_st.rdata = {st.base[reg_image_i], {`WINDOW_GRAIN_BITS{1'b0}}};
            end
         end
      end

      // eeprom load of size code and base enable
      if (eeprom_load_i && 32'(eeprom_image_i) < NUM_IMAGES)
      begin
         next_st.ctl[eeprom_image_i].window_size_code = eeprom_size_code_i;
         next_st.ctl[eeprom_image_i].base_reg_enable  = eeprom_base_reg_en_i;
      end

      // register write, reserved bits kept at zero
      if (reg_wr_i && 32'(reg_image_i) < NUM_IMAGES)
      begin
         if (reg_sel_i == `REG_SEL_CONTROL)
         begin
            next_st.ctl[reg_image_i]         = reg_wdata_i;
            next_st.ctl[reg_image_i].rsvd_hi = '0;
            next_st.ctl[reg_image_i].rsvd_lo = 1'b0;
         end
         else if (st.ctl[reg_image_i].base_reg_enable)
         begin
            next_st.base[reg_image_i] = reg_wdata_i[31 -: BASE_W];
         end
      end
   end

   // single state register
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         st <= state_reset();
      end
      else
      begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign reg_rdata_o                   = st.rdata;
   assign reg_rvalid_o                  = st.rvalid;
   assign claim_o                       = st.claim;
   assign config_claim_o                = st.cfg_claim;
   assign claim_image_o                 = st.image;
   assign fwd_addr_o                    = st.addr;
   assign fwd_cmd_o                     = st.cmd;
   assign fwd_write_o                   = st.write;
   assign fwd_byte_enables_n_o          = st.be_n;
   assign target_port_select_o          = st.attr.target_port_select;
   assign fwd_io_space_o                = st.attr.io_space_select;
   assign fwd_exact_read_o              = st.attr.exact_read_enable;
   assign translation_enable_o          = st.attr.translation_enable;
   assign window_size_code_o            = st.attr.window_size_code;
   assign proc_transfer_type_lines_o    = st.tt;
   // active-low cache signals driven low when their control bit is set
   assign proc_global_signal_n_o        = !st.attr.coherency_global_ctl;
   assign proc_cache_inhibit_signal_n_o = !st.attr.cache_inhibit_ctl;
   assign prefetch_retain_o             = st.attr.prefetch_retain_enable;
   assign byte_order_o                  = st.attr.byte_order;

endmodule
`default_nettype wire

// >>> rtl/pci_target_image_decode_params.svh
// constants for the pci target window decoder
`ifndef PCI_TARGET_IMAGE_DECODE_PARAMS_SVH
`define PCI_TARGET_IMAGE_DECODE_PARAMS_SVH

// register selector codes on the register port
`define REG_SEL_CONTROL 1'b0
`define REG_SEL_BASE    1'b1

// reset values of the window control fields
`define RST_DECODE_EN   1'b0
`define RST_XLATE_EN    1'b0
`define RST_BASE_REG_EN 1'b1
`define RST_SIZE_CODE   4'h0
`define RST_IO_SPACE    1'b0
`define RST_PORT_SEL    1'b0
`define RST_EXACT_READ  1'b0
`define RST_GLOBAL_CTL  1'b1
`define RST_CI_CTL      1'b1
`define RST_PREFETCH    1'b0
`define RST_BYTE_ORDER  2'h2
`define RST_BASE        16'h0000

// window granularity is 64 Kbyte, so the base holds address bits 31:16
`define WINDOW_GRAIN_BITS 16

// low address bits that mark a type 0 configuration access
`define TYPE0_ADDR_TAG 2'h0

// all byte lanes enabled (active low)
`define ALL_LANES_N 4'h0

`endif

// >>> rtl/pci_target_image_decode_pkg.sv
// types and command helpers for the pci target window decoder
package pci_target_image_decode_pkg;

   // bus command codes seen on the command/byte-enable lines
   typedef enum logic [3:0] {
      CMD_INT_ACK     = 4'h0,
      CMD_SPECIAL     = 4'h1,
      CMD_IO_RD       = 4'h2,
      CMD_IO_WR       = 4'h3,
      CMD_MEM_RD      = 4'h6,
      CMD_MEM_WR      = 4'h7,
      CMD_CFG_RD      = 4'ha,
      CMD_CFG_WR      = 4'hb,
      CMD_MEM_RD_MULT = 4'hc,
      CMD_DUAL_ADDR   = 4'hd,
      CMD_MEM_RD_LINE = 4'he,
      CMD_MEM_WR_INV  = 4'hf
   } pci_cmd_t;

   // byte-order codes
   typedef enum logic [1:0] {
      ORDER_LITTLE      = 2'h0,
      ORDER_PROC_LITTLE = 2'h1,
      ORDER_BIG         = 2'h2
   } byte_order_t;

   // address-phase tracker
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_LANES,
      BUS_BUSY
   } bus_state_t;

   // window control register, bit 31 down to bit 0
   typedef struct packed {
      logic [5:0] rsvd_hi;
      logic [1:0] byte_order;
      logic       prefetch_retain_enable;
      logic [4:0] proc_write_transfer_type;
      logic       cache_inhibit_ctl;
      logic       coherency_global_ctl;
      logic [4:0] proc_read_transfer_type;
      logic       exact_read_enable;
      logic       target_port_select;
      logic       io_space_select;
      logic [3:0] window_size_code;
      logic       rsvd_lo;
      logic       base_reg_enable;
      logic       translation_enable;
      logic       window_decode_enable;
   } ctl_t;

   // memory commands that windows decode
   function automatic logic is_mem_cmd(input logic [3:0] c);
      return c == CMD_MEM_RD || c == CMD_MEM_WR || c == CMD_MEM_RD_MULT
          || c == CMD_MEM_RD_LINE || c == CMD_MEM_WR_INV;
   endfunction

   // configuration commands
   function automatic logic is_cfg_cmd(input logic [3:0] c);
      return c == CMD_CFG_RD || c == CMD_CFG_WR;
   endfunction

   // write direction of a supported command
   function automatic logic is_write_cmd(input logic [3:0] c);
      return c == CMD_MEM_WR || c == CMD_MEM_WR_INV || c == CMD_CFG_WR;
   endfunction

endpackage

// >>> rtl/window_match.sv
// address range compare for one target window
`timescale 1ns/1ps
`default_nettype none

module window_match #(
   parameter int BASE_W = 16
) (
   input  wire logic              enable_i,
   input  wire logic              mem_cmd_i,
   input  wire logic [BASE_W-1:0] base_i,
   input  wire logic [3:0]        size_code_i,
   input  wire logic [31:0]       addr_i,
   output logic                   hit_o
);

   logic [BASE_W-1:0] size_mask;

   // size mask covers base to base plus size minus one
   always_comb
   begin
      size_mask = {BASE_W{1'b1}} << size_code_i;
      hit_o     = enable_i && mem_cmd_i
               && (((addr_i[31 -: BASE_W] ^ base_i) & size_mask) == '0);
   end

endmodule
`default_nettype wire

// >>> verif/pci_master_model.sv
// pci master model: one address phase and one data phase per access
`timescale 1ns/1ps
`default_nettype none

module pci_master_model (
   input  wire logic  clk_i,
   output logic        frame_n_o,
   output logic        irdy_n_o,
   output logic        idsel_o,
   output logic [31:0] ad_o,
   output logic [3:0]  cbe_o
);
   logic        drive;
   logic [31:0] ad_q;
   logic [31:0] junk;
   logic [3:0]  cbe_q;
   // released lines change every cycle so stale values never match
   assign ad_o = drive ? ad_q : junk;
   assign cbe_o = drive ? cbe_q : junk[3:0];
   initial
   begin
      {frame_n_o, irdy_n_o, idsel_o, drive} = 4'hc;
      {ad_q, cbe_q, junk} = {36'h0, 32'h0f0f_0f0f};
   end
   always @(posedge clk_i)
      junk <= ~junk;
   // address phase, byte enables, then bus returned to idle with a gap
   task automatic access(input logic [31:0] a, input logic [3:0] c, input logic s,
                         input logic [3:0] be);
      @(posedge clk_i);
      drive <= 1'b1;
      frame_n_o <= 1'b0;
      idsel_o <= s;
      ad_q <= a;
      cbe_q <= c;
      @(posedge clk_i);
      frame_n_o <= 1'b1;
      irdy_n_o <= 1'b0;
      ad_q <= ~a;
      cbe_q <= be;
      @(posedge clk_i);
      drive <= 1'b0;
      irdy_n_o <= 1'b1;
      idsel_o <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// >>> verif/pci_target_image_decode_asserts.sv
// port-level assertions for the pci target window decoder
`timescale 1ns/1ps
`default_nettype none

module pci_target_image_decode_asserts (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        pci_frame_n_i,
   input  wire logic        pci_irdy_n_i,
   input  wire logic        pci_idsel_i,
   input  wire logic [31:0] pci_addr_data_lines_i,
   input  wire logic [3:0]  pci_cmd_byte_enables_i,
   input  wire logic        reg_rd_i,
   input  wire logic        reg_rvalid_o,
   input  wire logic        claim_o,
   input  wire logic        config_claim_o,
   input  wire logic [31:0] fwd_addr_o,
   input  wire logic [3:0]  fwd_cmd_o,
   input  wire logic        fwd_write_o,
   input  wire logic [1:0]  byte_order_o
);
   logic        idle;
   logic        idsel_q;
   logic        ap;
   logic [3:0]  cmd_q;
   logic [31:0] addr_q;
   default clocking dflt @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // address phase: frame seen low while the bus tracker is idle
   assign ap = idle && !pci_frame_n_i;
   // bus tracker and address-phase capture
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         idle <= 1'b1;
      else if (ap)
         idle <= 1'b0;
      else if (pci_frame_n_i && pci_irdy_n_i)
         idle <= 1'b1;
      if (ap)
         {cmd_q, addr_q, idsel_q} <= {pci_cmd_byte_enables_i, pci_addr_data_lines_i, pci_idsel_i};
   end
   // address phase carrying a command the decoder must ignore
   sequence s_ap_other;
      ap && !(pci_cmd_byte_enables_i inside {4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'he, 4'hf});
   endsequence
   sequence s_any_claim;
      claim_o || config_claim_o;
   endsequence
   chk_claim_cause: assert property (claim_o |-> $past(ap, 2) &&
      cmd_q inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf}) else $error("claim without memory cycle");
   chk_cfg_type0: assert property (config_claim_o |-> $past(ap, 2) && idsel_q &&
      addr_q[1:0] == 2'h0 && cmd_q inside {4'ha, 4'hb}) else $error("bad config claim");
   chk_claim_pulse: assert property (s_any_claim |=> !claim_o && !config_claim_o)
      else $error("claim longer than one cycle");
   chk_ignore_other: assert property (s_ap_other |-> ##2 !claim_o && !config_claim_o)
      else $error("unsupported command claimed");
   chk_write_alias: assert property (claim_o |-> fwd_cmd_o == ((cmd_q == 4'hf) ? 4'h7 : cmd_q))
      else $error("forwarded command wrong");
   chk_fwd_addr: assert property (s_any_claim |-> fwd_addr_o == addr_q)
      else $error("forwarded address wrong");
   chk_write_dir: assert property (claim_o |-> fwd_write_o == (cmd_q inside {4'h7, 4'hf}))
      else $error("write direction wrong");
   chk_attr_hold: assert property (!claim_o |-> $stable(byte_order_o))
      else $error("byte order changed without claim");
   chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("register read not answered");
endmodule

bind pci_target_image_decode pci_target_image_decode_asserts pci_target_image_decode_asserts_i (
   .clk_i, .nrst_i, .pci_frame_n_i, .pci_irdy_n_i, .pci_idsel_i, .pci_addr_data_lines_i,
   .pci_cmd_byte_enables_i, .reg_rd_i, .reg_rvalid_o, .claim_o, .config_claim_o,
   .fwd_addr_o, .fwd_cmd_o, .fwd_write_o, .byte_order_o);
`default_nettype wire

// >>> verif/test_pci_target_image_decode.sv
// self-checking bench for the pci target window decoder
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) check_val(64'(g), 64'(e))

module test_pci_target_image_decode;
   typedef struct {
      logic [31:0] addr;
      logic [3:0]  cmd;
      logic        sel;
      int          mem;
      int          cfg;
      bit          img;
   } row_t;
   logic        clk_i, nrst_i, pci_frame_n_i, pci_irdy_n_i, pci_idsel_i, reg_wr_i, reg_rd_i;
   logic [31:0] pci_addr_data_lines_i, reg_wdata_i, reg_rdata_o, fwd_addr_o;
   logic [3:0]  pci_cmd_byte_enables_i, eeprom_size_code_i, fwd_cmd_o;
   logic [3:0]  fwd_byte_enables_n_o, window_size_code_o;
   logic [1:0]  reg_image_i, eeprom_image_i, claim_image_o, byte_order_o;
   logic        reg_sel_i, reg_rvalid_o, eeprom_load_i, eeprom_base_reg_en_i, claim_o;
   logic        config_claim_o, fwd_write_o, target_port_select_o, fwd_io_space_o;
   logic        fwd_exact_read_o, translation_enable_o, prefetch_retain_o;
   logic        proc_global_signal_n_o, proc_cache_inhibit_signal_n_o;
   logic [4:0]  proc_transfer_type_lines_o;
   int          n_mismatch, compares, n_claim, n_cfg, cycles;
   // window 0 at 0x1234 (64 Kbyte), window 1 at 0x2000 (256 Kbyte)
   row_t        rows[11] = '{
      '{32'h1234_0000, 4'h6, 1'b0, 1, 0, 1'b0}, '{32'h1234_fffc, 4'h7, 1'b0, 1, 0, 1'b0},
      '{32'h1235_0000, 4'h6, 1'b0, 0, 0, 1'b0}, '{32'h1233_fffc, 4'he, 1'b0, 0, 0, 1'b0},
      '{32'h2000_0000, 4'hf, 1'b0, 1, 0, 1'b1}, '{32'h2003_fff0, 4'hc, 1'b0, 1, 0, 1'b1},
      '{32'h2004_0000, 4'h6, 1'b0, 0, 0, 1'b0}, '{32'h0000_0100, 4'ha, 1'b1, 0, 1, 1'b0},
      '{32'h0000_0102, 4'hb, 1'b1, 0, 0, 1'b0}, '{32'h0000_0100, 4'hb, 1'b0, 0, 0, 1'b0},
      '{32'h1234_0010, 4'h2, 1'b1, 0, 0, 1'b0}};

   pci_target_image_decode pci_target_image_decode_i (
      .clk_i, .nrst_i, .pci_frame_n_i, .pci_irdy_n_i, .pci_idsel_i, .pci_addr_data_lines_i,
      .pci_cmd_byte_enables_i, .reg_wr_i, .reg_rd_i, .reg_image_i, .reg_sel_i, .reg_wdata_i,
      .reg_rdata_o, .reg_rvalid_o, .eeprom_load_i, .eeprom_image_i, .eeprom_size_code_i,
      .eeprom_base_reg_en_i, .claim_o, .config_claim_o, .claim_image_o, .fwd_addr_o,
      .fwd_cmd_o, .fwd_write_o, .fwd_byte_enables_n_o, .target_port_select_o,
      .fwd_io_space_o, .fwd_exact_read_o, .translation_enable_o, .window_size_code_o,
      .proc_transfer_type_lines_o, .proc_global_signal_n_o, .proc_cache_inhibit_signal_n_o,
      .prefetch_retain_o, .byte_order_o);
   pci_master_model pci_master_model_i (
      .clk_i, .frame_n_o(pci_frame_n_i), .irdy_n_o(pci_irdy_n_i), .idsel_o(pci_idsel_i),
      .ad_o(pci_addr_data_lines_i), .cbe_o(pci_cmd_byte_enables_i));
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // claim pulse counters and run-time ceiling
   always @(negedge clk_i)
   begin
      n_claim += int'(claim_o === 1'b1);
      n_cfg += int'(config_claim_o === 1'b1);
      cycles++;
      if (cycles == 4000)
      begin
         n_mismatch++;
         final_report();
      end
   end
   task automatic check_val(input logic [63:0] g, input logic [63:0] e);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // register write, or read with a check of the answer
   task automatic reg_op(input bit wr, input logic [1:0] i, input logic s, input logic [31:0] d);
      @(posedge clk_i);
      {reg_wr_i, reg_rd_i} <= {wr, !wr};
      reg_image_i <= i;
      reg_sel_i <= s;
      reg_wdata_i <= d;
      @(posedge clk_i);
      {reg_wr_i, reg_rd_i} <= 2'h0;
      @(negedge clk_i);
      if (!wr)
         `CHK({reg_rvalid_o, reg_rdata_o}, {1'b1, d});
   endtask
   task automatic access(input logic [31:0] a, input logic [3:0] c, input logic s,
                         input int mem, input int cfg);
      n_claim = 0;
      n_cfg = 0;
      pci_master_model_i.access(a, c, s, 4'ha);
      @(negedge clk_i);
      `CHK(n_claim, mem);
      `CHK(n_cfg, cfg);
   endtask
   // attributes of the claiming window
   task automatic check_attr(input bit i, input logic [31:0] a, input logic [3:0] c);
      logic w;
      w = c inside {4'h7, 4'hf};
      `CHK(claim_image_o, i);
      `CHK(fwd_addr_o, a);
      `CHK({fwd_cmd_o, fwd_write_o}, {(c == 4'hf) ? 4'h7 : c, w});
      `CHK({target_port_select_o, fwd_io_space_o, fwd_exact_read_o}, {3{i}});
      `CHK({translation_enable_o, prefetch_retain_o}, {2{!i}});
      `CHK({proc_global_signal_n_o, proc_cache_inhibit_signal_n_o}, {2{i}});
      `CHK({window_size_code_o, byte_order_o}, i ? 6'h08 : 6'h02);
      `CHK(proc_transfer_type_lines_o, i ? (w ? 5'h0a : 5'h05) : {4'h0, w});
      `CHK(fwd_byte_enables_n_o, (i && !w) ? 4'ha : 4'h0);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // main sequence
   initial
   begin
      int k;
      nrst_i = 1'b0;
      {reg_wr_i, reg_rd_i, reg_sel_i, eeprom_load_i, eeprom_base_reg_en_i} = 5'h0;
      {reg_image_i, eeprom_image_i, eeprom_size_code_i, reg_wdata_i} = 40'h0;
      repeat (16) @(posedge clk_i);
      nrst_i <= 1'b1;
      reg_op(1'b0, 2'h0, 1'b0, 32'h0207_0004);
      access(32'h0000_0000, 4'h6, 1'b0, 0, 0);
      done("reset");
      reg_op(1'b1, 2'h0, 1'b1, 32'h1234_5678);
      reg_op(1'b0, 2'h0, 1'b1, 32'h1234_0000);
      reg_op(1'b1, 2'h0, 1'b0, 32'h0287_0007);
      reg_op(1'b1, 2'h1, 1'b1, 32'h2000_0000);
      reg_op(1'b1, 2'h1, 1'b0, 32'hfc28_2f29);
      reg_op(1'b0, 2'h1, 1'b0, 32'h0028_2f21);
      for (k = 0; k < 11; k++)
      begin
         access(rows[k].addr, rows[k].cmd, rows[k].sel, rows[k].mem, rows[k].cfg);
         if (rows[k].mem != 0)
            check_attr(rows[k].img, rows[k].addr, rows[k].cmd);
         if (rows[k].cfg != 0)
            `CHK({fwd_addr_o[27:0], fwd_byte_enables_n_o}, {rows[k].addr[27:0], 4'ha});
      end
      done("rows");
      // every command code at a window address with type 0 select high
      for (k = 0; k < 16; k++)
      begin
         access(32'h1234_0040, k[3:0], 1'b1, int'(k inside {6, 7, 12, 14, 15}),
                int'(k inside {10, 11}));
         if (k inside {6, 7, 12, 14, 15})
            check_attr(1'b0, 32'h1234_0040, k[3:0]);
      end
      done("commands");
      reg_op(1'b1, 2'h0, 1'b0, 32'h0287_0003);
      reg_op(1'b0, 2'h0, 1'b1, 32'h0000_0000);
      reg_op(1'b1, 2'h0, 1'b1, 32'h5555_0000);
      reg_op(1'b1, 2'h0, 1'b0, 32'h0287_0007);
      reg_op(1'b0, 2'h0, 1'b1, 32'h1234_0000);
      done("base enable");
      @(posedge clk_i);
      eeprom_load_i <= 1'b1;
      eeprom_image_i <= 2'h2;
      eeprom_size_code_i <= 4'h3;
      @(posedge clk_i);
      eeprom_load_i <= 1'b0;
      reg_op(1'b0, 2'h2, 1'b0, 32'h0207_0030);
      done("eeprom");
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      reg_op(1'b0, 2'h0, 1'b0, 32'h0207_0004);
      access(32'h1234_0000, 4'h6, 1'b0, 0, 0);
      `CHK({translation_enable_o, prefetch_retain_o, byte_order_o}, 4'h2);
      done("second reset");
      final_report();
   end
endmodule
`default_nettype wire
